// File: rtl/stog_pkg.sv
// Package of constants and types for the self-test and output gate block.
package stog_pkg;
  localparam int RNG_BLOCK_W = 160;
  localparam int TEST_CNT = 9;
  localparam int TEST_IDX_W = 4;
  localparam logic [7:0] RC_NONE = 8'h00;
  localparam logic [7:0] RC_SUCCESS = 8'h01;
  localparam logic [7:0] RC_ERROR = 8'h02;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  localparam logic [2:0] PIN_SYNC_INIT = 3'h0;
  localparam logic [TEST_IDX_W-1:0] TEST_IDX_INIT = 4'h0;
  localparam logic [TEST_IDX_W-1:0] TEST_IDX_FW = 4'h8;
  typedef enum logic [2:0] {
    STOG_IDLE,
    STOG_START,
    STOG_WAIT,
    STOG_READY,
    STOG_ERROR
  } stog_state_t;
endpackage

// File: rtl/stog_top.sv
// Self-test sequencer, continuous generator checks and host output gate.
`timescale 1ns/1ps
`default_nettype none
module stog_top #(
  parameter int DATA_W = 8,
  parameter int BLOCK_W = stog_pkg::RNG_BLOCK_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic selftest_req,
  output logic [stog_pkg::TEST_IDX_W-1:0] test_sel,
  output logic test_start,
  input wire logic test_done,
  input wire logic test_pass,
  input wire logic drbg_valid,
  input wire logic [BLOCK_W-1:0] drbg_block,
  input wire logic entropy_valid,
  input wire logic [BLOCK_W-1:0] entropy_block,
  input wire logic keypair_valid,
  output logic pairwise_start,
  input wire logic pairwise_done,
  input wire logic pairwise_pass,
  input wire logic keygen_busy,
  input wire logic zeroize_busy,
  input wire logic host_in_valid,
  input wire logic [DATA_W-1:0] host_in_data,
  output logic core_in_valid,
  output logic [DATA_W-1:0] core_in_data,
  input wire logic core_out_valid,
  input wire logic [DATA_W-1:0] core_out_data,
  output logic host_out_valid,
  output logic [DATA_W-1:0] host_out_data,
  output logic crypto_enable,
  output logic session_clear,
  output logic [7:0] status_code,
  output logic error_state,
  output logic selftest_busy
);
  import stog_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;

  stog_state_t state;
  stog_state_t next_state;
  logic [TEST_IDX_W-1:0] idx;
  logic [TEST_IDX_W-1:0] next_idx;
  logic [7:0] next_status;

  logic [BLOCK_W-1:0] drbg_prev;
  logic [BLOCK_W-1:0] ent_prev;
  logic drbg_have;
  logic ent_have;

  logic pw_busy;
  logic [2:0] req_sync;
  logic req_seen;

  // Both data paths share this gating function, each with its own gate, so no word can slip past a closed gate.
  function automatic logic [DATA_W-1:0] gate_word(input logic open,
                                                  input logic [DATA_W-1:0] word);
    gate_word = open ? word : '0;
  endfunction

  // A block can only fail against a block seen since reset.
  function automatic logic blocks_repeat(input logic have, input logic [BLOCK_W-1:0] a,
                                         input logic [BLOCK_W-1:0] b);
    blocks_repeat = have && (a == b);
  endfunction

  // The release is synchronised so that no flop leaves reset on a different edge.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= RST_SYNC_INIT;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // The request pin passes three flops; a rise counts once the last two agree.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync <= PIN_SYNC_INIT;
    end else begin
      req_sync <= {req_sync[1:0], selftest_req};
    end
  end

  // Only the second and third flops are read, so the first may settle in private.
  wire req_level = req_sync[1] & req_sync[2];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen <= 1'b0;
    end else begin
      req_seen <= req_level;
    end
  end
  wire req_start = req_level & ~req_seen;

  wire st_idle = (state == STOG_IDLE);
  wire st_start = (state == STOG_START);
  wire st_wait = (state == STOG_WAIT);
  wire st_ready = (state == STOG_READY);
  wire st_error = (state == STOG_ERROR);

  // Any one failure is enough; the repeat checks run in every state, tests included.
  wire drbg_fail = drbg_valid && blocks_repeat(drbg_have, drbg_block, drbg_prev);
  wire ent_fail = entropy_valid && blocks_repeat(ent_have, entropy_block, ent_prev);
  wire pw_fail = pw_busy && pairwise_done && !pairwise_pass;
  wire kat_pass = st_wait && test_done && test_pass;
  wire kat_fail = st_wait && test_done && !test_pass;
  wire any_fail = drbg_fail | ent_fail | pw_fail | kat_fail;
  wire last_test = (idx == TEST_IDX_FW);

  // Power-on entry starts from idle with no trigger; a request in the ready state restarts the suite.
  always_comb begin
    next_state = state;
    case (state)
      STOG_IDLE: begin
        next_state = STOG_START;
      end
      STOG_START: begin
        next_state = STOG_WAIT;
      end
      STOG_WAIT: begin
        if (kat_pass) begin
          if (last_test) begin
            next_state = STOG_READY;
          end else begin
            next_state = STOG_START;
          end
        end
      end
      STOG_READY: begin
        if (req_start) begin
          next_state = STOG_START;
        end
      end
      STOG_ERROR: begin
        next_state = STOG_ERROR;
      end
      default: begin
        next_state = STOG_ERROR;
      end
    endcase
    if (any_fail) begin
      next_state = STOG_ERROR;
    end
  end

  // Apart from the return to TEST_IDX_INIT on a rerun, the index only moves on a passed test, so a failing test stays visible on test_sel.
  always_comb begin
    next_idx = idx;
    case (state)
      STOG_IDLE: begin
        next_idx = TEST_IDX_INIT;
      end
      STOG_WAIT: begin
        if (kat_pass && !last_test) begin
          next_idx = idx + 4'h1;
        end
      end
      STOG_READY: begin
        if (req_start) begin
          next_idx = TEST_IDX_INIT;
        end
      end
      default: begin
        next_idx = idx;
      end
    endcase
  end

  // Success is only reported for a completed suite outside the error state.
  assign next_status = (next_state == STOG_ERROR) ? RC_ERROR :
                       (st_wait && next_state == STOG_READY) ? RC_SUCCESS :
                       status_code;

  // Error has no exit but reset, so a passing rerun cannot hide an earlier failure.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= STOG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= TEST_IDX_INIT;
    end else begin
      idx <= next_idx;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_code <= RC_NONE;
    end else begin
      status_code <= next_status;
    end
  end

  // Previous blocks are forgotten at reset so the first block after it never fails.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drbg_prev <= '0;
      drbg_have <= 1'b0;
    end else if (drbg_valid) begin
      drbg_prev <= drbg_block;
      drbg_have <= 1'b1;
    end
  end

  // Entropy history has its own flops so one source never masks the other.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ent_prev <= '0;
      ent_have <= 1'b0;
    end else if (entropy_valid) begin
      ent_prev <= entropy_block;
      ent_have <= 1'b1;
    end
  end

  // A pair seen outside the ready state is still tracked so its result is not lost.
  wire pw_take = keypair_valid && !pw_busy;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_busy <= 1'b0;
    end else if (pw_take) begin
      pw_busy <= 1'b1;
    end else if (pairwise_done) begin
      pw_busy <= 1'b0;
    end
  end
  assign pairwise_start = pw_take && st_ready;

  // Busy stays high through reruns, so the host can tell testing from a finished suite.
  assign test_sel = idx;
  assign test_start = st_start;
  assign selftest_busy = !st_ready;
  assign error_state = st_error;
  assign crypto_enable = st_ready;
  assign session_clear = !rst_n || st_idle;

  wire in_open = st_ready;
  wire out_open = st_ready && !keygen_busy && !zeroize_busy;

  // Input is dropped, not queued, so nothing sent during testing runs later.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_in_valid <= 1'b0;
    end else begin
      core_in_valid <= host_in_valid && in_open;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_in_data <= '0;
    end else begin
      core_in_data <= gate_word(in_open, host_in_data);
    end
  end

  // The only route to the host output is this gated register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_out_valid <= 1'b0;
    end else begin
      host_out_valid <= core_out_valid && out_open;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_out_data <= '0;
    end else begin
      host_out_data <= gate_word(out_open, core_out_data);
    end
  end
endmodule // stog_top
`default_nettype wire

// File: sim/stog_chk.sv
// Checker tying the gate outputs to their causes.
`timescale 1ns/1ps
`default_nettype none
module stog_chk import stog_pkg::*; #(parameter int DATA_W = 8) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [TEST_IDX_W-1:0] test_sel,
  input wire logic test_start,
  input wire logic test_done,
  input wire logic test_pass,
  input wire logic keygen_busy,
  input wire logic zeroize_busy,
  input wire logic core_out_valid,
  input wire logic [DATA_W-1:0] core_out_data,
  input wire logic host_out_valid,
  input wire logic [DATA_W-1:0] host_out_data,
  input wire logic crypto_enable,
  input wire logic [7:0] status_code,
  input wire logic error_state
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // The output stage is registered, so its gate is judged one cycle back.
  a_out_gate: assert property (host_out_valid |->
    $past(crypto_enable && core_out_valid && !keygen_busy && !zeroize_busy)) else $error("gate");
  a_out_data: assert property (host_out_valid |->
    host_out_data == $past(core_out_data)) else $error("data");
  a_test_busy: assert property (test_start |-> !crypto_enable) else $error("busy");
  a_err_code: assert property (error_state |->
    !crypto_enable && status_code == RC_ERROR) else $error("code");
  a_err_hold: assert property (error_state |=> error_state) else $error("hold");
  a_kat_next: assert property (test_done && test_pass && test_sel < TEST_IDX_FW |=>
    test_start && test_sel == $past(test_sel) + 4'h1) else $error("order");
  a_fail_err: assert property (test_done && !test_pass |=> error_state) else $error("fail");
  a_pass_code: assert property (test_done && test_pass && test_sel == TEST_IDX_FW |=>
    status_code == RC_SUCCESS && crypto_enable) else $error("pass");
endmodule // stog_chk
bind stog_top stog_chk #(.DATA_W(DATA_W)) stog_chk_inst (.*);
`default_nettype wire

// File: sim/stog_engine_model.sv
// Test engine model answering each start after lat plus one cycles.
`timescale 1ns/1ps
`default_nettype none
module stog_engine_model (
  input wire logic ref_clk,
  input wire logic test_start,
  input wire logic [3:0] test_sel,
  input wire logic [3:0] fail_idx,
  input wire logic [3:0] lat,
  output logic test_done,
  output logic test_pass
);
  logic [4:0] cnt = 5'h0;
  // Pass toggles outside the done pulse, so a stray sample shows up.
  always @(posedge ref_clk) begin
    test_done <= cnt == 5'h1;
    test_pass <= cnt == 5'h1 ? test_sel != fail_idx : ~test_pass;
    cnt <= test_start ? 5'(lat) + 5'h1 : cnt - 5'(cnt != 5'h0);
  end
endmodule // stog_engine_model
`default_nettype wire

// File: sim/test_selftest_output_gate.sv
// Self-checking bench for the self-test gate.
`timescale 1ns/1ps
`default_nettype none
module test_selftest_output_gate;
  import stog_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n, selftest_req, drbg_valid, entropy_valid, keypair_valid, pairwise_done;
  logic pairwise_pass, keygen_busy, zeroize_busy, host_in_valid, core_out_valid, test_start;
  logic test_done, test_pass, pairwise_start, core_in_valid, host_out_valid, crypto_enable;
  logic session_clear, error_state, selftest_busy;
  logic [3:0] test_sel, fail_idx, lat;
  logic [7:0] host_in_data, core_in_data, core_out_data, host_out_data, status_code;
  logic [159:0] drbg_block, entropy_block;
  int err_count = 0, checked = 0, cyc = 0;
  stog_top stog_top_inst (.*);
  stog_engine_model stog_engine_model_inst (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_for(ref logic s);
    for (int i = 0; i < 300 && s !== 1'b1; i++) step(1);
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic boot(logic [3:0] f);
    fail_idx = f;
    arst_n = 1'b0;
    step(3);
    chk("session", 8'h1, 8'(session_clear));
    arst_n = 1'b1;
  endtask
  task automatic t_pass();
    boot(4'hf);
    wait_for(crypto_enable);
    step(1);
    chk("status", RC_SUCCESS, status_code);
    chk("in", 8'h5a, core_in_data);
    chk("out", 8'ha5, host_out_data);
    keygen_busy = 1'b1;
    step(2);
    chk("keygen", 8'h0, 8'(host_out_valid));
    keygen_busy = 1'b0;
    zeroize_busy = 1'b1;
    step(2);
    chk("zeroize", 8'h0, 8'(host_out_valid));
    zeroize_busy = 1'b0;
    selftest_req = 1'b1;
    wait_for(selftest_busy);
    step(1);
    chk("rerun", RC_SUCCESS, status_code);
    chk("rerun out", 8'h0, 8'(host_out_valid));
    chk("rerun in", 8'h0, 8'(core_in_valid));
    selftest_req = 1'b0;
    wait_for(crypto_enable);
    $display("t_pass end");
  endtask
  task automatic t_pair();
    keypair_valid = 1'b1;
    #1;
    chk("pair", 8'h1, 8'(pairwise_start));
    step(1);
    {keypair_valid, pairwise_done} = 2'b01;
    step(1);
    pairwise_done = 1'b0;
    step(2);
    chk("pair fail", 8'h1, 8'(error_state));
    chk("err out", 8'h0, 8'(host_out_valid));
    chk("err crypto", 8'h0, 8'(crypto_enable));
    selftest_req = 1'b1;
    step(8);
    chk("err held", 8'h1, 8'(error_state));
    selftest_req = 1'b0;
    step(4);
    $display("t_pair end");
  endtask
  task automatic t_fail();
    lat = 4'h0;
    for (int k = 0; k < TEST_CNT; k++) begin
      boot(4'(k));
      wait_for(error_state);
      chk("fail at", 8'(k), 8'(test_sel));
      chk("code", RC_ERROR, status_code);
    end
    $display("t_fail end");
  endtask
  task automatic send(bit ent, logic [159:0] v);
    {drbg_block, entropy_block} = {v, v};
    {drbg_valid, entropy_valid} = {!ent, ent};
    step(1);
    {drbg_valid, entropy_valid} = 2'b0;
    step(1);
  endtask
  task automatic t_repeat(bit ent);
    boot(4'hf);
    wait_for(crypto_enable);
    send(ent, 160'h1);
    send(ent, 160'h2);
    step(2);
    chk("fresh", 8'h0, 8'(error_state));
    send(ent, 160'h2);
    step(2);
    chk("repeat", 8'h1, 8'(error_state));
    $display("t_repeat end");
  endtask
  task automatic finish_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {arst_n, selftest_req, drbg_valid, entropy_valid, keypair_valid} = '0;
    {pairwise_done, pairwise_pass, keygen_busy, zeroize_busy, fail_idx, lat} = 12'h2;
    {host_in_valid, core_out_valid, host_in_data, core_out_data} = 18'h35aa5;
    {drbg_block, entropy_block} = '0;
    t_pass();
    t_pair();
    t_fail();
    t_repeat(1'b0);
    t_repeat(1'b1);
    finish_test();
  end
endmodule // test_selftest_output_gate
`default_nettype wire
